// ===== rtl/btt_pkg.sv
package btt_pkg;

  localparam int CLK_HZ   = 100_000_000;
  localparam int SLOW_HZ  = 32_768;
  localparam int FAST_HZ  = 4_000_000;
  localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam int FAST_DIV = CLK_HZ / FAST_HZ;
  localparam int DIV_W    = 12;

  localparam int NTMR   = 3;
  localparam int RT_W   = 14;
  localparam int BT_W   = 9;
  localparam int SYNC_N = 3;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TM0_CNT = 8'h00;
  localparam logic [7:0] IDX_TM0_CTL = 8'h01;
  localparam logic [7:0] IDX_TM0_EN  = 8'h02;
  localparam logic [7:0] IDX_TM1_CNT = 8'h04;
  localparam logic [7:0] IDX_TM1_CTL = 8'h05;
  localparam logic [7:0] IDX_TM1_EN  = 8'h06;
  localparam logic [7:0] IDX_TM2_CNT = 8'h08;
  localparam logic [7:0] IDX_TM2_CTL = 8'h09;
  localparam logic [7:0] IDX_TM2_EN  = 8'h0A;
  localparam logic [7:0] IDX_MIX     = 8'h2B;
  localparam logic [7:0] IDX_STATUS  = 8'h3C;
  localparam logic [7:0] IDX_MASK    = 8'h3D;
  localparam logic [7:0] IDX_STRIDE  = 8'h04;

  // Field positions
  localparam int CTL_SRC_LSB  = 0;
  localparam int CTL_RELOAD   = 4;
  localparam int EN_BIT       = 0;
  localparam int MIX_SINGLE   = 4;
  localparam int MIX_FT_SRC   = 5;
  localparam int CNT_MSB      = 7;

  // Reset values
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_CTL   = 8'h1E;
  localparam logic [7:0] RST_MIX   = 8'h00;
  localparam logic [2:0] RST_IRQ   = 3'h0;

  // Source select decode
  localparam logic [2:0] SRC_CHAIN  = 3'h0;
  localparam logic [2:0] SRC_RT13   = 3'h1;
  localparam int         RT_BASE    = 11;
  localparam int         BT_BASE    = 7;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] ctl;
    logic       en;
    logic       start;
  } btt_cfg_s;

  typedef struct packed {
    logic [7:0] count;
    logic       underflow;
    logic       running;
  } btt_stat_s;

endpackage : btt_pkg

// ===== rtl/btt_tickgen.sv
`timescale 1ns/1ps
module btt_tickgen
  import btt_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  output logic                 slow_tick,
  output logic [RT_W-1:0]      rt_ticks,
  output logic [BT_W:0]        bt_vec
);

  logic [DIV_W-1:0] sdiv_reg, sdiv_next;
  logic [DIV_W-1:0] fdiv_reg, fdiv_next;
  logic [RT_W-1:0]  rt_reg, rt_next;
  logic [BT_W-1:0]  bt_reg, bt_next;
  logic             fast_tick;

  assign slow_tick = (sdiv_reg == DIV_W'(SLOW_DIV - 1));
  assign fast_tick = (fdiv_reg == DIV_W'(FAST_DIV - 1));

  always_comb begin
    sdiv_next = slow_tick ? '0 : sdiv_reg + 1'b1;
    fdiv_next = fast_tick ? '0 : fdiv_reg + 1'b1;
    rt_next   = slow_tick ? rt_reg + 1'b1 : rt_reg;
    bt_next   = fast_tick ? bt_reg + 1'b1 : bt_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sdiv_reg <= '0;
      fdiv_reg <= '0;
      rt_reg   <= '0;
      bt_reg   <= '0;
    end else begin
      sdiv_reg <= sdiv_next;
      fdiv_reg <= fdiv_next;
      rt_reg   <= rt_next;
      bt_reg   <= bt_next;
    end
  end

  // Prescaler tap n ticks once every 2^(n+1) base ticks on rt_ticks, every 2^n base ticks on bt_vec
  assign bt_vec[0] = fast_tick;
  for (genvar n = 0; n < RT_W; n++) begin : g_rt
    assign rt_ticks[n] = slow_tick & (&rt_reg[n:0]);
  end
  for (genvar n = 0; n < BT_W; n++) begin : g_bt
    assign bt_vec[n+1] = fast_tick & (&bt_reg[n:0]);
  end

endmodule : btt_tickgen

// ===== rtl/btt_timer.sv
`timescale 1ns/1ps
module btt_timer
  import btt_pkg::*;
#(
  parameter int BT_SHIFT = 0
)(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire btt_cfg_s        cfg,
  input  wire logic            chain_tick,
  input  wire logic [RT_W-1:0] rt_ticks,
  input  wire logic [BT_W:0]   bt_vec,
  output btt_stat_s            stat
);

  logic [7:0] cnt_reg, cnt_next;
  logic       act_reg, act_next;
  logic       uf_reg, uf_next;
  logic       tick;
  logic [3:0] src;
  logic       reload;

  assign src    = cfg.ctl[CTL_SRC_LSB +: 4];
  assign reload = cfg.ctl[CTL_RELOAD];

  // Tick source select
  always_comb begin
    if (src[3:1] == SRC_CHAIN) begin
      tick = chain_tick;
    end else if (src[3:1] == SRC_RT13) begin
      tick = rt_ticks[RT_W-1];
    end else if (!src[3]) begin
      tick = rt_ticks[RT_BASE - 2 * int'(src[1:0])];
    end else begin
      tick = bt_vec[BT_BASE + BT_SHIFT - int'(src[2:0])];
    end
  end

  always_comb begin
    cnt_next = cnt_reg;
    act_next = act_reg;
    uf_next  = 1'b0;
    if (cfg.start) begin
      cnt_next = cfg.latch;
      act_next = 1'b1;
    end else if (!cfg.en) begin
      act_next = 1'b0;
    end else if (act_reg && tick) begin
      if (cnt_reg == 8'h00) begin
        if (reload) begin
          cnt_next = cfg.latch;
        end
      end else begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          uf_next = 1'b1;
          if (!reload) begin
            act_next = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= RST_LATCH;
      act_reg <= 1'b0;
      uf_reg  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      uf_reg  <= uf_next;
    end
  end

  assign stat.count     = cnt_reg;
  assign stat.underflow = uf_reg;
  assign stat.running   = act_reg;

endmodule : btt_timer

// ===== rtl/btt_top.sv
`timescale 1ns/1ps
module btt_top
  import btt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        alternate_toggle_clock,
  input  wire logic        cx_pin,
  output logic             buzzer_data,
  output logic             irq
);

  btt_cfg_s              cfg [NTMR];
  btt_stat_s             stat [NTMR];
  logic [NTMR-1:0]       chain;
  logic [RT_W-1:0]       rt_ticks;
  logic [BT_W:0]         bt_vec;
  logic                  slow_tick;

  logic [7:0]            latch_reg [NTMR];
  logic [7:0]            latch_next [NTMR];
  logic [7:0]            ctl_reg [NTMR];
  logic [7:0]            ctl_next [NTMR];
  logic [NTMR-1:0]       en_reg, en_next;
  logic [NTMR-1:0]       start_reg, start_next;
  logic [7:0]            mix_reg, mix_next;
  logic [NTMR-1:0]       sts_reg, sts_next;
  logic [NTMR-1:0]       mask_reg, mask_next;
  logic [31:0]           rdata_reg, rdata_next;
  logic                  err_reg, err_next;

  logic [SYNC_N-1:0]     ft_sync_reg, ft_sync_next;
  logic [SYNC_N-1:0]     cx_sync_reg, cx_sync_next;
  logic                  ft_lvl_reg, ft_lvl_next;
  logic                  cx_lvl_reg, cx_lvl_next;
  logic                  cx_rise;
  logic [NTMR-1:0]       msb_reg, msb_next;
  logic                  ch0_reg, ch0_next;
  logic                  ch1_reg, ch1_next;
  logic                  bz_reg, bz_next;
  logic                  mixed_tone_channel;

  logic                  setup_ph, wr_acc;
  logic [7:0]            idx;
  logic                  mapped;
  logic                  wr_lane0;

  logic [NTMR-1:0]       hit_cnt, hit_ctl, hit_en;

  // Bus decode
  assign setup_ph = psel && !penable;
  // A refused access never reaches the registers
  assign wr_acc   = psel && penable && pwrite && !err_reg;
  assign idx      = paddr[9:2];
  assign wr_lane0 = pstrb[0];
  // No wait states: every access phase completes at once
  assign pready   = psel && penable;
  assign prdata   = rdata_reg;
  assign pslverr  = err_reg && pready;

  // Per-timer register hits
  for (genvar t = 0; t < NTMR; t++) begin : g_hit
    assign hit_cnt[t] = (idx == IDX_TM0_CNT + IDX_STRIDE * 8'(t));
    assign hit_ctl[t] = (idx == IDX_TM0_CTL + IDX_STRIDE * 8'(t));
    assign hit_en[t]  = (idx == IDX_TM0_EN + IDX_STRIDE * 8'(t));
  end

  always_comb begin
    mapped = (paddr[1:0] == 2'b00) && (paddr[31:10] == '0);
    if (mapped) begin
      mapped = 1'b0;
      for (int t = 0; t < NTMR; t++) begin
        if (hit_cnt[t] || hit_ctl[t] || hit_en[t]) begin
          mapped = 1'b1;
        end
      end
      if (idx == IDX_MIX || idx == IDX_STATUS || idx == IDX_MASK) begin
        mapped = 1'b1;
      end
    end
  end

  // Read data captured in the setup cycle
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setup_ph) begin
      rdata_next = '0;
      err_next   = !mapped;
      for (int t = 0; t < NTMR; t++) begin
        if (hit_cnt[t]) begin
          rdata_next[7:0] = stat[t].count;
        end
        if (hit_ctl[t]) begin
          rdata_next[7:0] = ctl_reg[t];
        end
        if (hit_en[t]) begin
          rdata_next[EN_BIT] = en_reg[t];
        end
      end
      if (idx == IDX_MIX) begin
        rdata_next[7:0] = mix_reg;
      end
      if (idx == IDX_STATUS) begin
        rdata_next[NTMR-1:0] = sts_reg;
      end
      if (idx == IDX_MASK) begin
        rdata_next[NTMR-1:0] = mask_reg;
      end
    end
  end

  // Register writes
  always_comb begin
    mix_next   = mix_reg;
    mask_next  = mask_reg;
    en_next    = en_reg;
    // Start is a one-cycle strobe
    start_next = '0;
    sts_next   = sts_reg;
    for (int t = 0; t < NTMR; t++) begin
      latch_next[t] = latch_reg[t];
      ctl_next[t]   = ctl_reg[t];
    end
    if (wr_acc && wr_lane0) begin
      for (int t = 0; t < NTMR; t++) begin
        if (hit_cnt[t]) begin
          latch_next[t] = pwdata[7:0];
        end
        if (hit_ctl[t]) begin
          ctl_next[t] = pwdata[7:0];
        end
        if (hit_en[t]) begin
          en_next[t]    = pwdata[EN_BIT];
          start_next[t] = pwdata[EN_BIT];
        end
      end
      if (idx == IDX_MIX) begin
        mix_next = pwdata[7:0];
      end
      if (idx == IDX_MASK) begin
        mask_next = pwdata[NTMR-1:0];
      end
      if (idx == IDX_STATUS) begin
        sts_next = sts_reg & ~pwdata[NTMR-1:0];
      end
    end
    // Underflow sets win over a clear in the same cycle
    for (int t = 0; t < NTMR; t++) begin
      if (stat[t].underflow) begin
        sts_next[t] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int t = 0; t < NTMR; t++) begin
        latch_reg[t] <= RST_LATCH;
        ctl_reg[t]   <= RST_CTL;
      end
      en_reg    <= '0;
      start_reg <= '0;
      mix_reg   <= RST_MIX;
      sts_reg   <= RST_IRQ;
      mask_reg  <= RST_IRQ;
      rdata_reg <= '0;
      err_reg   <= 1'b0;
    end else begin
      for (int t = 0; t < NTMR; t++) begin
        latch_reg[t] <= latch_next[t];
        ctl_reg[t]   <= ctl_next[t];
      end
      en_reg    <= en_next;
      start_reg <= start_next;
      mix_reg   <= mix_next;
      sts_reg   <= sts_next;
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  // Level interrupt: sticky status under its mask
  assign irq = |(sts_reg & mask_reg);

  // Pin inputs: accept a change once stages two and three agree
  always_comb begin
    ft_sync_next = {ft_sync_reg[SYNC_N-2:0], alternate_toggle_clock};
    cx_sync_next = {cx_sync_reg[SYNC_N-2:0], cx_pin};
    ft_lvl_next  = ft_lvl_reg;
    cx_lvl_next  = cx_lvl_reg;
    if (ft_sync_reg[1] == ft_sync_reg[2]) begin
      ft_lvl_next = ft_sync_reg[2];
    end
    if (cx_sync_reg[1] == cx_sync_reg[2]) begin
      cx_lvl_next = cx_sync_reg[2];
    end
  end

  // One chained tick per accepted rising level
  assign cx_rise = cx_lvl_next && !cx_lvl_reg;

  // Chained sources: external pin, then previous counter MSB falling
  always_comb begin
    for (int t = 0; t < NTMR; t++) begin
      msb_next[t] = stat[t].count[CNT_MSB];
    end
    chain[0] = cx_rise;
    for (int t = 1; t < NTMR; t++) begin
      chain[t] = msb_reg[t-1] && !stat[t-1].count[CNT_MSB];
    end
  end

  // Tone channels and buzzer output
  always_comb begin
    ch0_next = ch0_reg;
    ch1_next = ch1_reg;
    bz_next  = bz_reg;
    if (stat[0].underflow) begin
      ch0_next = !ch0_reg;
    end
    if (stat[1].underflow) begin
      ch1_next = !ch1_reg;
    end
    if (slow_tick) begin
      bz_next = mix_reg[MIX_FT_SRC] ? ft_lvl_reg : mixed_tone_channel;
    end
  end

  assign mixed_tone_channel = mix_reg[MIX_SINGLE] ? ch0_reg : (ch0_reg ^ ch1_reg);

  always_ff @(posedge clk) begin
    if (reset) begin
      ft_sync_reg <= '0;
      cx_sync_reg <= '0;
      ft_lvl_reg  <= 1'b0;
      cx_lvl_reg  <= 1'b0;
      msb_reg     <= '0;
      ch0_reg     <= 1'b0;
      ch1_reg     <= 1'b0;
      bz_reg      <= 1'b0;
    end else begin
      ft_sync_reg <= ft_sync_next;
      cx_sync_reg <= cx_sync_next;
      ft_lvl_reg  <= ft_lvl_next;
      cx_lvl_reg  <= cx_lvl_next;
      msb_reg     <= msb_next;
      ch0_reg     <= ch0_next;
      ch1_reg     <= ch1_next;
      bz_reg      <= bz_next;
    end
  end

  // Registered so the pin only moves on slow ticks
  assign buzzer_data = bz_reg;

  // Shared prescalers feed every timer source except the chained one
  btt_tickgen u_tickgen (
    .clk       (clk),
    .reset     (reset),
    .slow_tick (slow_tick),
    .rt_ticks  (rt_ticks),
    .bt_vec    (bt_vec)
  );

  for (genvar t = 0; t < NTMR; t++) begin : g_tmr
    assign cfg[t].latch = latch_reg[t];
    assign cfg[t].ctl   = ctl_reg[t];
    assign cfg[t].en    = en_reg[t];
    assign cfg[t].start = start_reg[t];
    btt_timer #(
      .BT_SHIFT ((t == NTMR - 1) ? 2 : 0)
    ) u_timer (
      .clk        (clk),
      .reset      (reset),
      .cfg        (cfg[t]),
      .chain_tick (chain[t]),
      .rt_ticks   (rt_ticks),
      .bt_vec     (bt_vec),
      .stat       (stat[t])
    );
  end

endmodule : btt_top

// ===== verification/btt_checker.sv
`timescale 1ns/1ps
module btt_checker
  import btt_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        alternate_toggle_clock,
  input wire logic        cx_pin,
  input wire logic        buzzer_data,
  input wire logic        irq
);
  logic [2:0]  mask_reg;
  logic [15:0] gap_reg;
  logic        bz_reg;
  logic        acc;
  logic        clr_wr;
  logic        cnt_rd;

  function automatic logic mapped(input logic [31:0] a);
    return (a[31:8] == 24'h00_0000) && (a[7:0] inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18,
      8'h20, 8'h24, 8'h28, 8'hAC, 8'hF0, 8'hF4});
  endfunction : mapped

  assign acc    = psel && penable;
  assign clr_wr = acc && pwrite && pstrb[0] && (paddr == 32'h0000_00F0 || paddr == 32'h0000_00F4);
  assign cnt_rd = acc && !pwrite && (paddr == 32'h0000_0000 || paddr == 32'h0000_0010 || paddr == 32'h0000_0020);

  // Shadow of the mask and spacing of buzzer changes
  always_ff @(posedge clk) begin
    bz_reg <= buzzer_data;
    if (reset) begin
      mask_reg <= 3'h0;
      gap_reg  <= 16'hFFFF;
    end else begin
      if (acc && pwrite && pstrb[0] && paddr == 32'h0000_00F4) mask_reg <= pwdata[2:0];
      if (buzzer_data != bz_reg) gap_reg <= 16'h0000;
      else if (gap_reg != 16'hFFFF) gap_reg <= gap_reg + 16'h0001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_ACCESS_READY: assert property (pready == acc) else $error("pready not tied to access phase");
  AST_ERR_IN_ACCESS: assert property (pslverr |-> acc) else $error("error outside access phase");
  AST_UNMAPPED_ERR: assert property (acc && !mapped(paddr) |-> pslverr) else $error("unmapped access accepted");
  AST_UNMAPPED_ZERO: assert property (acc && !pwrite && !mapped(paddr) |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_COUNT_BYTE: assert property (cnt_rd |-> prdata[31:8] == 24'h00_0000)
    else $error("count read has upper bits");
  AST_BUZZ_SLOW: assert property (buzzer_data != bz_reg |-> gap_reg >= SLOW_DIV - 1)
    else $error("buzzer changed between slow ticks");
  AST_IRQ_RISE: assert property ($rose(irq) |-> mask_reg != 3'h0)
    else $error("irq rose while masked");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(clr_wr) || $past(clr_wr, 2) || $past(reset))
    else $error("irq fell without clear");
  AST_RESET_QUIET: assert property ($fell(reset) |-> !irq && !buzzer_data && !pslverr)
    else $error("outputs active after reset");

  COV_IRQ: cover property ($rose(irq));
  COV_BUZZ: cover property (buzzer_data != bz_reg);
  COV_UNMAPPED: cover property (acc && !mapped(paddr));
endmodule : btt_checker

bind btt_top btt_checker u_chk (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .alternate_toggle_clock, .cx_pin, .buzzer_data, .irq);

// ===== verification/btt_piezo.sv
`timescale 1ns/1ps
module btt_piezo (
  input wire logic clk,
  input wire logic clear,
  input wire logic buzzer_data,
  output int       edge_count
);
  logic last_lvl = 1'b0;

  // Counts membrane reversals since the last clear
  always_ff @(posedge clk) begin
    last_lvl <= buzzer_data;
    if (clear) edge_count <= 0;
    else if (buzzer_data !== last_lvl) edge_count <= edge_count + 1;
  end
endmodule : btt_piezo

// ===== verification/tb_buzzer_tone_timers.sv
`timescale 1ns/1ps
module tb_buzzer_tone_timers;
  import btt_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        alternate_toggle_clock = 1'b0, cx_pin = 1'b0, piezo_clear = 1'b0;
  logic        pready, pslverr, buzzer_data, irq, err;
  int          edge_count, miscompares = 0, total_checks = 0, cyc = 0, n, t1, t2;
  logic [7:0]  ra [12] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'hAC, 8'hF0, 8'hF4};

  btt_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alternate_toggle_clock(alternate_toggle_clock), .cx_pin(cx_pin), .buzzer_data(buzzer_data), .irq(irq));
  btt_piezo u_piezo (.clk(clk), .clear(piezo_clear), .buzzer_data(buzzer_data), .edge_count(edge_count));

  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic near(input int seen, input int exp, input int tol);
    check({31'h0, (seen >= exp - tol) && (seen <= exp + tol)}, 32'h0000_0001);
  endtask : near

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {24'h00_0000, a};
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      miscompares++;
      print_verdict();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic poll(output int t);
    for (int i = 0; i < 600; i++) begin
      apb(1'b0, 8'hF0, 32'h0000_0000, 4'hF);
      if (rd[0] === 1'b1) begin
        t = cyc;
        return;
      end
    end
    miscompares++;
    print_verdict();
  endtask : poll

  task automatic window(input int exp, input int tol, input bit ft);
    repeat (3100) @(posedge clk);
    piezo_clear <= 1'b1;
    @(posedge clk);
    piezo_clear <= 1'b0;
    for (int i = 0; i < 16000; i++) begin
      @(posedge clk);
      if (ft && i % 4000 == 2000) alternate_toggle_clock <= !alternate_toggle_clock;
    end
    near(edge_count, exp, tol);
  endtask : window

  initial begin
    void'($urandom(32'h17b6_275b));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, ra[i], 32'h0000_0000, 4'hF);
      check(rd, (i % 3 == 1 && i < 9) ? 32'h0000_001E : 32'h0000_0000);
    end
    apb(1'b0, 8'h0C, 32'h0000_0000, 4'hF);
    check({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, 8'hAC, 32'h0000_0030, 4'h0);
    apb(1'b0, 8'hAC, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0000);
    wr(8'h00, {24'h00_0000, 8'($urandom_range(255, 1))});
    apb(1'b0, 8'h00, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0000);
    n = $urandom_range(6, 2);
    wr(8'h00, n);
    wr(8'h04, 32'h0000_001F); // fastest timer source
    wr(8'h08, 32'h0000_0001);
    apb(1'b0, 8'h00, 32'h0000_0000, 4'hF);
    check({31'h0, rd === n || rd === n - 1}, 32'h0000_0001);
    poll(t1);
    wr(8'hF0, 32'h0000_0001);
    poll(t1);
    wr(8'hF0, 32'h0000_0001);
    poll(t2);
    near(t2 - t1, (n + 1) * FAST_DIV, 4);
    wr(8'h08, 32'h0000_0000);
    wr(8'h04, 32'h0000_000F);
    wr(8'h00, 32'h0000_0003);
    wr(8'hF0, 32'h0000_0007);
    wr(8'hF4, 32'h0000_0001);
    wr(8'h08, 32'h0000_0001);
    poll(t1);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    wr(8'hF4, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wr(8'hF4, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    wr(8'hF0, 32'h0000_0001);
    repeat (400) @(posedge clk);
    check(irq, 1'b0);
    apb(1'b0, 8'h00, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0000);
    wr(8'h00, 32'h0000_0095);
    wr(8'h04, 32'h0000_001F);
    wr(8'h08, 32'h0000_0001);
    wr(8'hAC, 32'h0000_0010);
    window(16000 / (150 * FAST_DIV), 1, 1'b0);
    wr(8'h08, 32'h0000_0000);
    wr(8'h10, 32'h0000_00C7);
    wr(8'h14, 32'h0000_001F);
    wr(8'h18, 32'h0000_0001);
    window(0, 0, 1'b0);
    wr(8'hAC, 32'h0000_0000);
    window(16000 / (200 * FAST_DIV), 1, 1'b0);
    wr(8'hAC, 32'h0000_0020);
    window(4, 1, 1'b1);
    wr(8'h04, 32'h0000_0010);
    wr(8'h00, 32'h0000_0002);
    wr(8'hF0, 32'h0000_0007);
    wr(8'h08, 32'h0000_0001);
    for (int p = 1; p >= 0; p--) begin
      cx_pin <= 1'b1;
      repeat (8) @(posedge clk);
      cx_pin <= 1'b0;
      repeat (8) @(posedge clk);
      apb(1'b0, 8'h00, 32'h0000_0000, 4'hF);
      check(rd, p);
    end
    apb(1'b0, 8'hF0, 32'h0000_0000, 4'hF);
    check(rd[0], 1'b1);
    print_verdict();
  end
endmodule : tb_buzzer_tone_timers
